// file: core/srcal_params.svh
// Overview of operation
// - Averaging-select bits 3:2 pick 4, 16, 64 or 256 averages; reset code 1.
// - Larger averaging code runs more passes, longer calibration, lower result spread.
// - Duration code makes each accumulation last 4, 16, 64 or 256 cycles; reset 1.
// - SYSREF period beyond the limit fails calibration; no valid delay reported.
// - Longer accumulation for fixed period lengthens calibration and lowers result spread.
// - Completion flag bit 17 reads 1 only while enabled and sequence finished.
// - Computed 17-bit delay in status bits 16:0; valid only when flag is 1.
// - Delay bit 16 is inversion, bits 15:8 coarse, bits 7:0 fine.
// - Status register is read-only; contents meaningless until a result exists.
// - Manual delay-adjust resets to zero: invert bit 16, coarse 15:8, fine 7:0.
// - A 0-to-1 change of calibration enable launches the calibration sequence.
// - Enabled: calibrated delay drives clock once done, last delay held until then; manual register ignored; disabled: manual drives.
// - Manual inversion bit set inverts the sampling clock.
`ifndef SRCAL_PARAMS_SVH
`define SRCAL_PARAMS_SVH

`define SRCAL_ADDR_W          12
`define SRCAL_DATA_W          24
`define SRCAL_OFS_ENABLE      12'h2B0
`define SRCAL_OFS_CONFIG      12'h2B1
`define SRCAL_OFS_STATUS      12'h2B2
`define SRCAL_OFS_DELAY_ADJ   12'h2B5
`define SRCAL_RST_ENABLE      8'h00
`define SRCAL_RST_CONFIG      8'h05
`define SRCAL_RST_DELAY_ADJ   24'h000000
`define SRCAL_ENABLE_BIT      0
`define SRCAL_AVG_MSB         3
`define SRCAL_AVG_LSB         2
`define SRCAL_DUR_MSB         1
`define SRCAL_DUR_LSB         0
`define SRCAL_DONE_BIT        17
`define SRCAL_INV_BIT         16
`define SRCAL_MAX_PER0        128
`define SRCAL_MAX_PER1        1664
`define SRCAL_MAX_PER2        7808
`define SRCAL_MAX_PER3        32384

`endif

// file: core/srcal_pkg.sv
package srcal_pkg;

  typedef enum logic [2:0] {
    SRCAL_IDLE  = 3'h0,
    SRCAL_WAIT  = 3'h1,
    SRCAL_ACCUM = 3'h3,
    SRCAL_DONE  = 3'h2,
    SRCAL_FAIL  = 3'h6
  } srcal_state_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
  } srcal_req_s;

  typedef struct packed {
    logic        inv;
    logic [7:0]  coarse;
    logic [7:0]  fine;
  } srcal_delay_s;

  typedef struct packed {
    logic [2:0] sync;
    logic       level;
  } srcal_sync_s;

endpackage : srcal_pkg

// file: core/srcal_sync.sv
`timescale 1ns/1ns
`default_nettype none
module srcal_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous pin and its filtered level
  input  wire logic pin_in,
  output var  logic level_out
);
  import srcal_pkg::*;

  srcal_sync_s st_reg;
  srcal_sync_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.sync = {st_reg.sync[1:0], pin_in};
    // Change accepted once stages two and three agree
    if (st_reg.sync[1] == st_reg.sync[2]) begin
      st_next.level = st_reg.sync[2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;
endmodule : srcal_sync
`default_nettype wire

// file: core/srcal_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "srcal_params.svh"
module srcal_top #(
  parameter int MAX_PER0 = `SRCAL_MAX_PER0,
  parameter int MAX_PER1 = `SRCAL_MAX_PER1,
  parameter int MAX_PER2 = `SRCAL_MAX_PER2,
  parameter int MAX_PER3 = `SRCAL_MAX_PER3
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Register port
  input  wire srcal_pkg::srcal_req_s  reg_req,
  output var  logic [23:0]            reg_rdata,
  // Timing reference and phase detector pins
  input  wire logic                   sysref_in,
  input  wire logic                   phase_in,
  // Delay control to the sample clock path
  output var  srcal_pkg::srcal_delay_s delay_out,
  output var  logic                   cal_fail
);
  import srcal_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Types and decode

  typedef struct packed {
    logic [7:0]   enable;
    logic [7:0]   config_r;
    logic [23:0]  adjust;
    logic [16:0]  result;
    logic         done;
    logic         fail;
    srcal_state_e state;
    logic         sysref_d;
    logic [14:0]  per_cnt;
    logic [8:0]   acc_cnt;
    logic [8:0]   avg_cnt;
    logic [16:0]  sum;
    logic [23:0]  rdata;
    srcal_delay_s delay;
  } srcal_top_s;

  // Code 0..3 to 4, 16, 64, 256
  function automatic logic [8:0] code_count(input logic [1:0] code);
    code_count = 9'h004 << {code, 1'b0};
  endfunction : code_count

  function automatic logic [14:0] max_period(input logic [1:0] code);
    case (code)
      2'h0:    max_period = 15'(MAX_PER0);
      2'h1:    max_period = 15'(MAX_PER1);
      2'h2:    max_period = 15'(MAX_PER2);
      default: max_period = 15'(MAX_PER3);
    endcase
  endfunction : max_period

  // One-hot register select, shared by the write and read paths
  function automatic logic [3:0] reg_select(input logic [11:0] addr);
    if (addr == `SRCAL_OFS_ENABLE) begin
      reg_select = 4'h1;
    end else if (addr == `SRCAL_OFS_CONFIG) begin
      reg_select = 4'h2;
    end else if (addr == `SRCAL_OFS_STATUS) begin
      reg_select = 4'h4;
    end else if (addr == `SRCAL_OFS_DELAY_ADJ) begin
      reg_select = 4'h8;
    end else begin
      reg_select = 4'h0;
    end
  endfunction : reg_select

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] pins_raw;
  logic [1:0] pins_s;

  assign pins_raw = {phase_in, sysref_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      srcal_sync u_sync (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (pins_raw[gi]),
        .level_out (pins_s[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // State update

  srcal_top_s st_reg;
  srcal_top_s st_next;

  logic [8:0]  avg_n;
  logic [8:0]  dur_n;
  logic [14:0] per_max;
  logic        sysref_rise;
  logic        en_bit;
  logic [3:0]  reg_sel;

  assign avg_n       = code_count(st_reg.config_r[`SRCAL_AVG_MSB:`SRCAL_AVG_LSB]);
  assign dur_n       = code_count(st_reg.config_r[`SRCAL_DUR_MSB:`SRCAL_DUR_LSB]);
  assign per_max     = max_period(st_reg.config_r[`SRCAL_DUR_MSB:`SRCAL_DUR_LSB]);
  assign sysref_rise = pins_s[0] & ~st_reg.sysref_d;
  assign en_bit      = st_reg.enable[`SRCAL_ENABLE_BIT];
  assign reg_sel     = reg_select(reg_req.addr);

  always_comb begin
    st_next          = st_reg;
    st_next.sysref_d = pins_s[0];

    // Register writes; status has no write path
    if (reg_req.wr) begin
      if (reg_sel[0]) begin
        st_next.enable = reg_req.wdata[7:0];
      end else if (reg_sel[1]) begin
        st_next.config_r = reg_req.wdata[7:0];
      end else if (reg_sel[3]) begin
        st_next.adjust = reg_req.wdata;
      end
    end

    // Period watchdog between SYSREF edges
    if (sysref_rise) begin
      st_next.per_cnt = '0;
    end else if (st_reg.per_cnt != 15'h7FFF) begin
      st_next.per_cnt = st_reg.per_cnt + 15'h0001;
    end

    case (st_reg.state)
      SRCAL_IDLE: begin
        if (st_next.enable[`SRCAL_ENABLE_BIT] && !en_bit) begin
          st_next.state   = SRCAL_WAIT;
          st_next.sum     = '0;
          st_next.avg_cnt = '0;
          st_next.fail    = 1'b0;
          st_next.done    = 1'b0;
        end
      end
      SRCAL_WAIT, SRCAL_ACCUM: begin
        if (st_reg.per_cnt >= per_max) begin
          st_next.state = SRCAL_FAIL;
          st_next.fail  = 1'b1;
        end else if (st_reg.state == SRCAL_WAIT) begin
          if (sysref_rise) begin
            st_next.state   = SRCAL_ACCUM;
            st_next.acc_cnt = '0;
          end
        end else begin
          st_next.sum     = st_reg.sum + {16'h0000, pins_s[1]};
          st_next.acc_cnt = st_reg.acc_cnt + 9'h001;
          if (st_reg.acc_cnt == dur_n - 9'h001) begin
            st_next.avg_cnt = st_reg.avg_cnt + 9'h001;
            if (st_reg.avg_cnt == avg_n - 9'h001) begin
              st_next.state  = SRCAL_DONE;
              st_next.done   = 1'b1;
              st_next.result = st_next.sum;
            end else begin
              st_next.state = SRCAL_WAIT;
            end
          end
        end
      end
      SRCAL_DONE, SRCAL_FAIL: begin
      end
      default: begin
        st_next.state = SRCAL_IDLE;
      end
    endcase

    // Disable aborts and clears completion
    if (!st_next.enable[`SRCAL_ENABLE_BIT]) begin
      st_next.state = SRCAL_IDLE;
      st_next.done  = 1'b0;
    end

    // Delay source select
    if (en_bit) begin
      st_next.delay = st_reg.done ? srcal_delay_s'(st_reg.result) : st_reg.delay;
    end else begin
      st_next.delay = srcal_delay_s'(st_reg.adjust[16:0]);
    end

    // Read data, one cycle after the strobe
    st_next.rdata = '0;
    if (reg_req.rd) begin
      if (reg_sel[0]) begin
        st_next.rdata = {16'h0000, st_reg.enable};
      end else if (reg_sel[1]) begin
        st_next.rdata = {16'h0000, st_reg.config_r};
      end else if (reg_sel[2]) begin
        st_next.rdata = {6'h00, st_reg.done & en_bit, st_reg.result};
      end else if (reg_sel[3]) begin
        st_next.rdata = st_reg.adjust;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.enable   <= `SRCAL_RST_ENABLE;
      st_reg.config_r <= `SRCAL_RST_CONFIG;
      st_reg.adjust   <= `SRCAL_RST_DELAY_ADJ;
      st_reg.state    <= SRCAL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = st_reg.rdata;
  assign delay_out = st_reg.delay;
  assign cal_fail  = st_reg.fail;

endmodule : srcal_top
`default_nettype wire

// file: sim/srcal_clkgen.sv
`timescale 1ns/1ns
`default_nettype none
module srcal_clkgen (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Period in clocks and phase level
  input  wire logic [15:0] per,
  input  wire logic        lvl,
  // Reference and detector pins
  output var  logic        sysref,
  output var  logic        phase
);
  logic [15:0] cnt_reg;
  // Free-running periodic reference
  always_ff @(posedge clk) begin
    if (rst || cnt_reg >= per - 16'h0001) cnt_reg <= 16'h0000;
    else cnt_reg <= cnt_reg + 16'h0001;
  end
  assign sysref = cnt_reg < (per >> 1);
  assign phase = lvl;
endmodule : srcal_clkgen
`default_nettype wire

// file: sim/srcal_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module srcal_top_props (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Register port
  input  wire srcal_pkg::srcal_req_s   reg_req,
  input  wire logic [23:0]             reg_rdata,
  // Pins and delay control
  input  wire logic                    sysref_in,
  input  wire logic                    phase_in,
  input  wire srcal_pkg::srcal_delay_s delay_out,
  input  wire logic                    cal_fail
);
  import srcal_pkg::*;
  logic [7:0]  en_reg;
  logic [7:0]  cfg_reg;
  logic [16:0] adj_reg;
  wire logic   rd0 = reg_req.rd && reg_req.addr == 12'h2B0;
  wire logic   rd1 = reg_req.rd && reg_req.addr == 12'h2B1;
  wire logic   rd2 = reg_req.rd && reg_req.addr == 12'h2B2;
  wire logic   mapped = reg_req.addr inside {12'h2B0, 12'h2B1, 12'h2B2, 12'h2B5};
  // Shadow of the writable registers
  always_ff @(posedge clk) begin
    if (rst) begin
      en_reg <= 8'h00;
      cfg_reg <= 8'h05;
      adj_reg <= 17'h00000;
    end else if (reg_req.wr) begin
      if (reg_req.addr == 12'h2B0) en_reg <= reg_req.wdata[7:0];
      if (reg_req.addr == 12'h2B1) cfg_reg <= reg_req.wdata[7:0];
      if (reg_req.addr == 12'h2B5) adj_reg <= reg_req.wdata[16:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  idle_rdata_a: assert property (!reg_req.rd |=> reg_rdata == 24'h000000)
    else $error("read data not zero without read");
  enable_rd_a: assert property (rd0 |=> reg_rdata == {16'h0000, $past(en_reg)})
    else $error("enable read back wrong");
  config_rd_a: assert property (rd1 |=> reg_rdata == {16'h0000, $past(cfg_reg)})
    else $error("config read back wrong");
  status_rd_a: assert property (rd2 |=> reg_rdata[23:18] == 6'h00
    && (!reg_rdata[17] || $past(en_reg[0])))
    else $error("status read wrong");
  unmapped_rd_a: assert property (reg_req.rd && !mapped |=> reg_rdata == 24'h000000)
    else $error("unmapped read not zero");
  manual_delay_a: assert property (!$past(en_reg[0]) |-> delay_out == $past(adj_reg))
    else $error("manual delay not applied");
  fail_when_en_a: assert property ($rose(cal_fail) |-> $past(en_reg[0]))
    else $error("failure without enable");
  launch_clears_a: assert property (reg_req.wr && reg_req.addr == 12'h2B0
    && reg_req.wdata[0] && !en_reg[0] |-> ##[1:4] !cal_fail)
    else $error("launch kept failure");
  fail_nodone_a: assert property (cal_fail && rd2 |=> !reg_rdata[17])
    else $error("done with failure");
endmodule : srcal_top_props
bind srcal_top srcal_top_props u_srcal_top_props (.clk(clk), .rst(rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .sysref_in(sysref_in), .phase_in(phase_in),
  .delay_out(delay_out), .cal_fail(cal_fail));
`default_nettype wire

// file: sim/srcal_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module srcal_top_tb;
  import srcal_pkg::*;
  logic         clk;
  logic         rst;
  logic         lvl;
  logic         sysref;
  logic         phase;
  logic         cal_fail;
  logic [15:0]  per;
  logic [23:0]  reg_rdata;
  srcal_req_s   req;
  srcal_delay_s delay_out;
  int           num_errors = 0;
  int           n_checks = 0;
  srcal_top u_srcal_top (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata),
    .sysref_in(sysref), .phase_in(phase), .delay_out(delay_out), .cal_fail(cal_fail));
  srcal_clkgen u_srcal_clkgen (.clk(clk), .rst(rst), .per(per), .lvl(lvl),
    .sysref(sysref), .phase(phase));
  always #10 clk = ~clk;
  task automatic close_out();
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [23:0] d,
                     output logic [23:0] q);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk) req <= '0;
    #1 q = reg_rdata;
  endtask : acc
  function automatic logic [23:0] exp_stat(input logic [1:0] a, d, input logic l);
    return {7'h01, l ? 17'h00001 << (4 + 2 * a + 2 * d) : 17'h00000};
  endfunction : exp_stat
  // Configure, launch, poll until done or failed
  task automatic run_cal(input logic [1:0] a, d, input logic [15:0] p, output logic [23:0] q);
    @(posedge clk) per <= p;
    lvl <= 1'($urandom);
    // Let the old spacing age out so the launch sees only the new period
    repeat (2 * p + 16) @(posedge clk);
    acc(1'b1, 12'h2B1, {20'h00000, a, d}, q);
    acc(1'b1, 12'h2B0, 24'h000001, q);
    q = '0;
    for (int k = 0; k < 30000 && q[17] !== 1'b1 && cal_fail !== 1'b1; k++)
      acc(1'b0, 12'h2B2, 24'h000000, q);
  endtask : run_cal
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    logic [11:0] ad [5];
    logic [23:0] rv [5];
    logic [23:0] q, v, e;
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    per = 16'h0064;
    lvl = 1'b0;
    void'($urandom(32'hAE9F3EBA));
    ad = '{12'h2B0, 12'h2B1, 12'h2B2, 12'h2B5, 12'h2B3};
    rv = '{24'h000000, 24'h000005, 24'h000000, 24'h000000, 24'h000000};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, ad[i], 24'h000000, q);
      chk(q, rv[i]);
    end
    acc(1'b1, 12'h2B2, 24'($urandom), q);
    acc(1'b0, 12'h2B2, 24'h000000, q);
    chk(q, 24'h000000);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 24'h010000 : 24'($urandom) & 24'h01FFFF;
      acc(1'b1, 12'h2B5, v, q);
      acc(1'b0, 12'h2B5, 24'h000000, q);
      chk(q, v);
      chk({7'h00, delay_out}, v);
    end
    // Mid-run reset brings the manual delay back to zero
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 12'h2B5, 24'h000000, q);
    chk(q, 24'h000000);
    chk({7'h00, delay_out}, 24'h000000);
    for (int i = 0; i < 4; i++) begin
      run_cal(2'(i), 2'(3 - i), (i == 0) ? 16'h012C + 16'($urandom % 100)
                                         : 16'h003C + 16'($urandom % 60), q);
      e = exp_stat(2'(i), 2'(3 - i), lvl);
      chk(q, e);
      v = 24'($urandom) & 24'h01FFFF;
      acc(1'b1, 12'h2B5, v, q);
      chk({7'h01, delay_out}, e);
      acc(1'b1, 12'h2B0, 24'h000000, q);
      acc(1'b0, 12'h2B2, 24'h000000, q);
      chk({23'h000000, q[17]}, 24'h000000);
      chk({7'h00, delay_out}, v);
    end
    run_cal(2'h0, 2'h0, 16'h00C8, q);
    chk({23'h000000, cal_fail}, 24'h000001);
    chk({23'h000000, q[17]}, 24'h000000);
    acc(1'b1, 12'h2B0, 24'h000000, q);
    run_cal(2'h0, 2'h0, 16'h0064, q);
    chk({23'h000000, cal_fail}, 24'h000000);
    chk(q, exp_stat(2'h0, 2'h0, lvl));
    close_out();
  end
endmodule : srcal_top_tb
`default_nettype wire
